// >>> shared/i2c_irq_pkg.sv
/*
  Shared constants for the interrupt gating and serial clock timing block:
  register offsets, reset values, field positions and phase multipliers.
  Assumes 8-bit registers reached over a plain strobe port.
*/
package i2c_irq_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL_MAIN   = 4'h0;
  localparam logic [3:0] OFS_CTRL_BUS    = 4'h1;
  localparam logic [3:0] OFS_CLK_FREQ    = 4'h2;
  localparam logic [3:0] OFS_OWN_LOW     = 4'h3;
  localparam logic [3:0] OFS_OWN_HIGH    = 4'h4;
  localparam logic [3:0] OFS_DATA        = 4'h6;
  localparam logic [3:0] OFS_STAT_EVT    = 4'h7;
  localparam logic [3:0] OFS_STAT_ERR    = 4'h8;
  localparam logic [3:0] OFS_STAT_BUS    = 4'h9;
  localparam logic [3:0] OFS_IRQ_EN      = 4'ha;
  localparam logic [3:0] OFS_DIV_LOW     = 4'hb;
  localparam logic [3:0] OFS_DIV_HIGH    = 4'hc;
  localparam logic [3:0] OFS_RISE        = 4'hd;

  // ----------------------------------------
  // reset values and writable bit masks
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_DIV_LOW     = 8'h00;
  localparam logic [7:0] RST_RISE        = 8'h02;
  localparam logic [7:0] MASK_CLK_FREQ   = 8'h3f;
  localparam logic [7:0] MASK_OWN_HIGH   = 8'hc6;
  localparam logic [7:0] MASK_STAT_EVT   = 8'hdf;
  localparam logic [7:0] MASK_STAT_ERR   = 8'h2f;
  localparam logic [7:0] MASK_STAT_BUS   = 8'h17;
  localparam logic [7:0] MASK_IRQ_EN     = 8'h07;
  localparam logic [7:0] MASK_DIV_HIGH   = 8'hcf;
  localparam logic [7:0] MASK_RISE       = 8'h3f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BIT_PE         = 0;
  localparam int unsigned BIT_ERR_EN     = 0;
  localparam int unsigned BIT_EVT_EN     = 1;
  localparam int unsigned BIT_BUF_EN     = 2;
  localparam int unsigned BIT_START      = 0;
  localparam int unsigned BIT_ADDR       = 1;
  localparam int unsigned BIT_BYTE_DONE  = 2;
  localparam int unsigned BIT_TEN_HDR    = 3;
  localparam int unsigned BIT_STOP       = 4;
  localparam int unsigned BIT_RX_FULL    = 6;
  localparam int unsigned BIT_TX_EMPTY   = 7;
  localparam int unsigned BIT_WAKE       = 5;
  localparam int unsigned BIT_FAST       = 7;
  localparam int unsigned BIT_DUTY       = 6;
  localparam int unsigned DIV_W          = 12;
  localparam int unsigned RISE_W         = 6;
  localparam int unsigned CNT_W          = 16;

  // ----------------------------------------
  // phase multipliers of the divider
  // ----------------------------------------
  localparam logic [4:0] MUL_ONE         = 5'h01;
  localparam logic [4:0] MUL_FAST_LOW    = 5'h02;
  localparam logic [4:0] MUL_DUTY_HIGH   = 5'h09;
  localparam logic [4:0] MUL_DUTY_LOW    = 5'h10;
endpackage : i2c_irq_pkg

// >>> shared/scl_timing_if.sv
/*
  Carrier between the register block and the serial clock generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface scl_timing_if;
  import i2c_irq_pkg::*;
  logic [DIV_W-1:0]  divider;
  logic              fast;
  logic              duty;
  logic [RISE_W-1:0] rise_limit;
  logic              run;
  logic              line_high;
  logic              drive_low;
  logic              phase_high;

  // settings and line level flow to the generator, drive and phase state back
  modport ctl (output divider, fast, duty, rise_limit, run, line_high,
               input drive_low, phase_high);
  modport gen (input divider, fast, duty, rise_limit, run, line_high,
               output drive_low, phase_high);
endinterface : scl_timing_if
`default_nettype wire

// >>> rtl/scl_clock_gen.sv
/*
  Master serial clock generator: counts high and low phases from the
  divider. Assumes the line level arrives already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_clock_gen (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // settings and line
  scl_timing_if.gen tim
);
  import i2c_irq_pkg::*;

  // ----------------------------------------
  // phase lengths
  // ----------------------------------------
  typedef enum logic [1:0] {GEN_IDLE, GEN_LOW, GEN_HIGH} gen_state_e;

  gen_state_e       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [4:0]       mul_high, mul_low;
  logic [CNT_W-1:0] len_high, len_low;
  logic             stretch;

  // high/low multipliers per speed and duty
  assign mul_high = (tim.fast && tim.duty) ? MUL_DUTY_HIGH : MUL_ONE;
  assign mul_low  = !tim.fast ? MUL_ONE :
                    (tim.duty ? MUL_DUTY_LOW : MUL_FAST_LOW);
  assign len_high = CNT_W'(tim.divider * mul_high);
  assign len_low  = CNT_W'(tim.divider * mul_low);
  // hold the count once the rise allowance is used and the line is still low
  assign stretch  = !tim.line_high && (cnt_reg >= CNT_W'(tim.rise_limit));

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  // counts start at release or pull, so each phase includes its own edge
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      GEN_IDLE: begin
        cnt_next = '0;
        if (tim.run) begin
          state_next = GEN_LOW;
        end
      end
      GEN_LOW: begin
        if (cnt_reg >= len_low - 1'b1) begin
          state_next = GEN_HIGH;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      GEN_HIGH: begin
        if (stretch) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg >= len_high - 1'b1) begin
          state_next = tim.run ? GEN_LOW : GEN_IDLE;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    endcase
  end

  // state and counter, run drops to idle at once from the low phase, after the high phase ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= GEN_IDLE;
      cnt_reg   <= '0;
    end else if (!tim.run && state_reg == GEN_LOW) begin
      state_reg <= GEN_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign tim.drive_low  = (state_reg == GEN_LOW);
  assign tim.phase_high = (state_reg == GEN_HIGH);
endmodule : scl_clock_gen
`default_nettype wire

// >>> rtl/i2c_irq_scl_top.sv
/*
  Register block of the two-wire controller: status flags, interrupt
  gating and master serial clock timing. Assumes the transfer sequencer
  supplies flag set/clear pulses on clk_sys, and an external open-drain
  pad resolves the serial clock line.
*/
// Decided for this implementation: the address-and-strobe port.
// Overview of operation
// - transmit-empty or receive-full interrupt only when buffer enable is set.
// - start, address, ten-bit header and stop flags raise event interrupt when enabled.
// - byte finished flag is its own event interrupt source.
// - buffer flags need both event and buffer enables.
// - halt wakeup flag raises the event interrupt.
// - bus, arbitration, acknowledge, overrun errors raise error interrupt when enabled.
// - standard mode: high and low both divider times input period.
// - fast duty zero: high is divider, low twice divider.
// - fast duty one: high nine, low sixteen times divider.
// - divider is twelve bits from low register and high register low nibble.
// - high phase counts its rising edge, low phase its falling edge.
// - upper five interrupt enable bits read zero.
// - event and error status flags clear while peripheral is disabled; bus status keeps following its input.
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_scl_top (
  // clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  // register port
  input  wire logic [i2c_irq_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [i2c_irq_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [i2c_irq_pkg::DATA_W-1:0]   reg_rdata,
  // flag sources from the transfer sequencer
  input  wire logic [7:0]                       evt_set,
  input  wire logic [7:0]                       evt_clr,
  input  wire logic [7:0]                       err_set,
  input  wire logic [7:0]                       bus_state,
  input  wire logic [7:0]                       rx_byte,
  input  wire logic                             rx_load,
  input  wire logic                             master_run,
  input  wire logic                             halt_wake,
  // configuration towards the sequencer
  output logic                                  peripheral_enable,
  output logic      [7:0]                       ctrl_bus_actions,
  output logic      [7:0]                       tx_byte,
  output logic                                  data_wr_pulse,
  output logic                                  data_rd_pulse,
  output logic                                  scl_high_phase,
  // interrupts
  output logic                                  event_irq,
  output logic                                  error_irq,
  // serial clock pin, open drain
  input  wire logic                             scl_in,
  output logic                                  scl_out,
  output logic                                  scl_oe_n
);
  import i2c_irq_pkg::*;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] ctrl_main_reg;
  logic [7:0] ctrl_bus_reg;
  logic [7:0] clk_freq_reg;
  logic [7:0] own_low_reg;
  logic [7:0] own_high_reg;
  logic [7:0] data_reg, data_next;
  logic [7:0] stat_evt_reg, stat_evt_next;
  logic [7:0] stat_err_reg, stat_err_next;
  logic [7:0] stat_bus_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic [7:0] rise_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic       event_irq_reg, event_irq_next;
  logic       error_irq_reg, error_irq_next;
  logic       data_wr_reg;
  logic       data_rd_reg;
  logic       scl_oe_n_reg;
  logic       scl_phase_reg;
  logic       scl_meta_reg, scl_sync_reg;
  logic       wake_meta_reg, wake_sync_reg, wake_last_reg;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic wr_ctrl_main, wr_ctrl_bus, wr_clk_freq, wr_own_low;
  logic wr_own_high, wr_data, wr_stat_err, wr_irq_en;
  logic wr_div_low, wr_div_high, wr_rise, rd_data;
  logic pe;

  // one write strobe per writable register
  assign wr_ctrl_main = reg_wr && (reg_addr == OFS_CTRL_MAIN);
  assign wr_ctrl_bus  = reg_wr && (reg_addr == OFS_CTRL_BUS);
  assign wr_clk_freq  = reg_wr && (reg_addr == OFS_CLK_FREQ);
  assign wr_own_low   = reg_wr && (reg_addr == OFS_OWN_LOW);
  assign wr_own_high  = reg_wr && (reg_addr == OFS_OWN_HIGH);
  assign wr_data      = reg_wr && (reg_addr == OFS_DATA);
  assign wr_stat_err  = reg_wr && (reg_addr == OFS_STAT_ERR);
  assign wr_irq_en    = reg_wr && (reg_addr == OFS_IRQ_EN);
  assign wr_div_low   = reg_wr && (reg_addr == OFS_DIV_LOW);
  assign wr_div_high  = reg_wr && (reg_addr == OFS_DIV_HIGH);
  assign wr_rise      = reg_wr && (reg_addr == OFS_RISE);
  assign rd_data      = reg_rd && (reg_addr == OFS_DATA);
  assign pe           = ctrl_main_reg[BIT_PE];

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // divider and rise limit are only taken while disabled: a change under
  // a running clock would cut a phase short
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_main_reg <= RST_ZERO;
      ctrl_bus_reg  <= RST_ZERO;
      clk_freq_reg  <= RST_ZERO;
      own_low_reg   <= RST_ZERO;
      own_high_reg  <= RST_ZERO;
      irq_en_reg    <= RST_ZERO;
      div_low_reg   <= RST_DIV_LOW;
      div_high_reg  <= RST_ZERO;
      rise_reg      <= RST_RISE;
    end else begin
      if (wr_ctrl_main) ctrl_main_reg <= reg_wdata;
      if (wr_ctrl_bus)  ctrl_bus_reg  <= reg_wdata;
      if (wr_clk_freq)  clk_freq_reg  <= reg_wdata & MASK_CLK_FREQ;
      if (wr_own_low)   own_low_reg   <= reg_wdata;
      if (wr_own_high)  own_high_reg  <= reg_wdata & MASK_OWN_HIGH;
      if (wr_irq_en)    irq_en_reg    <= reg_wdata & MASK_IRQ_EN;
      if (wr_div_low && !pe)  div_low_reg  <= reg_wdata;
      if (wr_div_high && !pe) div_high_reg <= reg_wdata & MASK_DIV_HIGH;
      if (wr_rise && !pe)     rise_reg     <= reg_wdata & MASK_RISE;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  logic evt_en, err_en, buf_en, wake_rise;

  assign evt_en    = irq_en_reg[BIT_EVT_EN];
  assign err_en    = irq_en_reg[BIT_ERR_EN];
  assign buf_en    = irq_en_reg[BIT_BUF_EN];
  assign wake_rise = wake_sync_reg && !wake_last_reg;

  // set wins over any clear in the same cycle; disable wipes everything
  always_comb begin
    stat_evt_next = ((stat_evt_reg & ~evt_clr) | evt_set) & MASK_STAT_EVT;
    if (!pe) begin
      stat_evt_next = RST_ZERO;
    end
  end

  // error bits clear on a written 0, wakeup sets only with events enabled
  always_comb begin
    stat_err_next = stat_err_reg;
    if (wr_stat_err) begin
      stat_err_next = stat_err_reg & reg_wdata;
    end
    stat_err_next = (stat_err_next | err_set) & MASK_STAT_ERR;
    if (wake_rise && evt_en) begin
      stat_err_next[BIT_WAKE] = 1'b1;
    end
    if (!pe) begin
      stat_err_next = RST_ZERO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_evt_reg <= RST_ZERO;
      stat_err_reg <= RST_ZERO;
      stat_bus_reg <= RST_ZERO;
    end else begin
      stat_evt_reg <= stat_evt_next;
      stat_err_reg <= stat_err_next;
      stat_bus_reg <= bus_state & MASK_STAT_BUS;
    end
  end

  // ----------------------------------------
  // data register
  // ----------------------------------------
  // a new received byte takes precedence over a software write
  assign data_next = rx_load ? rx_byte : (wr_data ? reg_wdata : data_reg);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_reg    <= RST_ZERO;
      data_wr_reg <= 1'b0;
      data_rd_reg <= 1'b0;
    end else begin
      data_reg    <= data_next;
      data_wr_reg <= wr_data;
      data_rd_reg <= rd_data;
    end
  end

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  logic evt_plain, evt_buffer, err_any;

  // plain event sources, byte finished counted on its own
  assign evt_plain  = stat_evt_reg[BIT_START] | stat_evt_reg[BIT_ADDR]
                    | stat_evt_reg[BIT_TEN_HDR] | stat_evt_reg[BIT_STOP]
                    | stat_evt_reg[BIT_BYTE_DONE]
                    | stat_err_reg[BIT_WAKE];
  // buffer flags only pass with the buffer enable too
  assign evt_buffer = buf_en & (stat_evt_reg[BIT_TX_EMPTY]
                    | stat_evt_reg[BIT_RX_FULL]);
  assign err_any    = |(stat_err_reg & MASK_STAT_ERR & ~(8'h01 << BIT_WAKE));

  assign event_irq_next = evt_en & (evt_plain | evt_buffer);
  assign error_irq_next = err_en & err_any;

  // outputs are registered, so each line trails its flags by one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_irq_reg <= 1'b0;
      error_irq_reg <= 1'b0;
    end else begin
      event_irq_reg <= event_irq_next;
      error_irq_reg <= error_irq_next;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr)
      OFS_CTRL_MAIN: rdata_next = ctrl_main_reg;
      OFS_CTRL_BUS:  rdata_next = ctrl_bus_reg;
      OFS_CLK_FREQ:  rdata_next = clk_freq_reg;
      OFS_OWN_LOW:   rdata_next = own_low_reg;
      OFS_OWN_HIGH:  rdata_next = own_high_reg;
      OFS_DATA:      rdata_next = data_reg;
      OFS_STAT_EVT:  rdata_next = stat_evt_reg;
      OFS_STAT_ERR:  rdata_next = stat_err_reg;
      OFS_STAT_BUS:  rdata_next = stat_bus_reg;
      OFS_IRQ_EN:    rdata_next = irq_en_reg & MASK_IRQ_EN;
      OFS_DIV_LOW:   rdata_next = div_low_reg;
      OFS_DIV_HIGH:  rdata_next = div_high_reg;
      OFS_RISE:      rdata_next = rise_reg;
      default:       rdata_next = RST_ZERO;
    endcase
  end

  // data only stands in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= RST_ZERO;
    end else begin
      rdata_reg <= reg_rd ? rdata_next : RST_ZERO;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two stages before any logic looks at the line or the wake pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_meta_reg  <= 1'b1;
      scl_sync_reg  <= 1'b1;
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
      wake_last_reg <= 1'b0;
    end else begin
      scl_meta_reg  <= scl_in;
      scl_sync_reg  <= scl_meta_reg;
      wake_meta_reg <= halt_wake;
      wake_sync_reg <= wake_meta_reg;
      wake_last_reg <= wake_sync_reg;
    end
  end

  // ----------------------------------------
  // serial clock generator
  // ----------------------------------------
  scl_timing_if tim ();

  // divider joins low register and high register nibble
  assign tim.divider    = {div_high_reg[3:0], div_low_reg};
  assign tim.fast       = div_high_reg[BIT_FAST];
  assign tim.duty       = div_high_reg[BIT_DUTY];
  assign tim.rise_limit = rise_reg[RISE_W-1:0];
  assign tim.run        = pe && master_run;
  assign tim.line_high  = scl_sync_reg;

  scl_clock_gen u_gen (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tim     (tim)
  );

  // pin only ever pulled low; enable low means driving
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_oe_n_reg  <= 1'b1;
      scl_phase_reg <= 1'b0;
    end else begin
      scl_oe_n_reg  <= !tim.drive_low;
      scl_phase_reg <= tim.phase_high;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata         = rdata_reg;
  assign peripheral_enable = ctrl_main_reg[BIT_PE];
  assign ctrl_bus_actions  = ctrl_bus_reg;
  assign tx_byte           = data_reg;
  assign data_wr_pulse     = data_wr_reg;
  assign data_rd_pulse     = data_rd_reg;
  assign scl_high_phase    = scl_phase_reg;
  assign event_irq         = event_irq_reg;
  assign error_irq         = error_irq_reg;
  assign scl_out           = 1'b0;
  assign scl_oe_n          = scl_oe_n_reg;
endmodule : i2c_irq_scl_top
`default_nettype wire

// >>> sim/i2c_irq_scl_top_asserts.sv
/* checker on the top ports of i2c_irq_scl_top
   assumes flag, irq and serial clock timing as handed over */
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_scl_top_asserts (
  // watched ports
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] evt_set,
  input wire logic [7:0] err_set,
  input wire logic       master_run,
  input wire logic       peripheral_enable,
  input wire logic       event_irq,
  input wire logic       error_irq,
  input wire logic       scl_oe_n
);
  logic [2:0]       en_reg;
  logic [7:0]       dl_reg;
  logic [7:0]       dh_reg;
  logic [15:0]      lc_reg;
  wire logic [15:0] mul = !dh_reg[7] ? 16'h0001 : dh_reg[6] ? 16'h0010 : 16'h0002;
  wire logic [15:0] low_exp = {4'h0, dh_reg[3:0], dl_reg} * mul;
  wire logic        wr_cfg = reg_wr && !peripheral_enable;
  // shadows; divider writes only land while disabled
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_reg <= 3'h0;
      dl_reg <= 8'h00;
      dh_reg <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 4'ha) en_reg <= reg_wdata[2:0];
      if (wr_cfg && reg_addr == 4'hb) dl_reg <= reg_wdata;
      if (wr_cfg && reg_addr == 4'hc) dh_reg <= reg_wdata;
    end
  end
  // cycles the line has been pulled so far
  always_ff @(posedge clk_sys) lc_reg <= scl_oe_n ? 16'h0000 : lc_reg + 16'h0001;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_err;
    err_set[3:0] != 4'h0 && peripheral_enable ##1 peripheral_enable && en_reg[0] && !reg_wr;
  endsequence
  sequence s_evt;
    evt_set[4:0] != 5'h00 && peripheral_enable ##1 peripheral_enable && en_reg[1];
  endsequence
  AST_RST_QUIET: assert property ($past(rst) |-> scl_oe_n && !event_irq && !error_irq)
    else $error("busy after reset");
  AST_EN_READ: assert property (reg_rd && reg_addr == 4'ha |=> reg_rdata == {5'h00, en_reg})
    else $error("enable readback");
  AST_PE_OFF: assert property (!peripheral_enable [*3] |-> !event_irq && !error_irq)
    else $error("irq while disabled");
  AST_ERR_GATE: assert property (error_irq |-> $past(en_reg[0]))
    else $error("error irq ungated");
  AST_EVT_GATE: assert property (event_irq |-> $past(en_reg[1]))
    else $error("event irq ungated");
  AST_ERR_RISE: assert property (s_err |=> error_irq)
    else $error("error irq missing");
  AST_EVT_RISE: assert property (s_evt |=> event_irq)
    else $error("event irq missing");
  AST_LOW_LEN: assert property (master_run [*4] ##0 $rose(scl_oe_n) |-> lc_reg == low_exp)
    else $error("low phase length");
endmodule : i2c_irq_scl_top_asserts
bind i2c_irq_scl_top i2c_irq_scl_top_asserts chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_set(evt_set),
  .err_set(err_set), .master_run(master_run), .peripheral_enable(peripheral_enable),
  .event_irq(event_irq), .error_irq(error_irq), .scl_oe_n(scl_oe_n));
`default_nettype wire

// >>> sim/scl_far_side.sv
/* far side of the clock line: pull-up and a slave that may stretch
   assumes scl_oe_n low means the master pulls the line */
`timescale 1ns/1ps
`default_nettype none
module scl_far_side (
  // clock and pad
  input  wire logic       clk_sys,
  input  wire logic       scl_oe_n,
  input  wire logic [3:0] stretch,
  output logic            scl_line
);
  logic [3:0] hold_reg = 4'h0;
  // slow slave keeps the line low a few cycles after release
  always_ff @(posedge clk_sys) begin
    if (!scl_oe_n) hold_reg <= stretch;
    else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
  end
  // open drain, pulled high when nobody pulls
  assign scl_line = scl_oe_n && (hold_reg == 4'h0);
endmodule : scl_far_side
`default_nettype wire

// >>> sim/i2c_irq_scl_top_bench.sv
/* bench for i2c_irq_scl_top: register port, flag pulses, clock phases
   assumes scl_far_side as the line and the bound checker */
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_scl_top_bench;
  import i2c_irq_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, run = 1'b0, wake = 1'b0;
  logic [3:0] addr = 4'h0, stretch = 4'h0;
  logic [7:0] wd = 8'h00, es = 8'h00, ec = 8'h00, rs = 8'h00, rdat;
  logic       pe, ev_irq, er_irq, oe_n, line, hp;
  int         n_fail = 0, total_checks = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  i2c_irq_scl_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdat), .evt_set(es), .evt_clr(ec), .err_set(rs), .bus_state(8'h00),
    .rx_byte(8'h00), .rx_load(1'b0), .master_run(run), .halt_wake(wake), .peripheral_enable(pe),
    .ctrl_bus_actions(), .tx_byte(), .data_wr_pulse(), .data_rd_pulse(), .scl_high_phase(hp),
    .event_irq(ev_irq), .error_irq(er_irq), .scl_in(line), .scl_out(), .scl_oe_n(oe_n));
  scl_far_side far (.clk_sys(clk_sys), .scl_oe_n(oe_n), .stretch(stretch), .scl_line(line));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // one access plus an idle cycle, so a strobe is never set twice at once
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk_sys);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    #1 if (!w) chk({8'h00, rdat}, {8'h00, d});
    @(posedge clk_sys);
  endtask : acc
  task automatic irq(input logic [1:0] e);
    @(posedge clk_sys);
    #1 chk({14'h0000, ev_irq, er_irq}, {14'h0000, e});
    @(posedge clk_sys);
  endtask : irq
  // flag pulses; irq lags the pulse by two edges
  task automatic fl(input logic [7:0] s, input logic [7:0] r, input logic [7:0] c, input logic [1:0] e);
    es <= s;
    rs <= r;
    ec <= c;
    @(posedge clk_sys);
    es <= 8'h00;
    rs <= 8'h00;
    ec <= 8'h00;
    @(posedge clk_sys);
    irq(e);
  endtask : fl
  // program while disabled, then time one low and one high phase
  task automatic ph(input logic [7:0] dh, input logic [7:0] dl, input logic [3:0] st,
                    input logic [7:0] tr, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] n;
    stretch <= st;
    acc(1, 4'h0, 8'h00);
    acc(1, 4'hd, tr);
    acc(1, 4'hb, dl);
    acc(1, 4'hc, dh);
    acc(1, 4'h0, 8'h01);
    acc(1, 4'hb, ~dl);
    acc(0, 4'hb, dl);
    acc(0, 4'hc, dh & 8'hcf);
    run <= 1'b1;
    for (n = 0; oe_n !== 1'b0 && n < 99; n++) @(negedge clk_sys);
    for (n = 0; oe_n === 1'b0 && n < 999; n++) @(negedge clk_sys);
    chk(n, lo);
    chk({15'h0000, hp}, 16'h0001);
    for (n = 0; oe_n === 1'b1 && n < 999; n++) @(negedge clk_sys);
    chk(n, hi);
    @(posedge clk_sys);
    run <= 1'b0;
  endtask : ph
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 14; i++) acc(0, 4'(i), (i == 13) ? 8'h02 : 8'h00);
    acc(1, 4'h5, 8'hff);
    acc(0, 4'h5, 8'h00);
    acc(1, 4'ha, 8'hff);
    acc(0, 4'ha, 8'h07);
    acc(1, 4'h0, 8'h01);
    chk({15'h0000, pe}, 16'h0001);
    acc(1, 4'ha, 8'h01);
    for (int i = 0; i < 4; i++) begin
      fl(8'h00, 8'h01 << i, 8'h00, 2'b01);
      acc(1, 4'h8, 8'h00);
      irq(2'b00);
    end
    acc(1, 4'ha, 8'h00);
    fl(8'h00, 8'h0f, 8'h00, 2'b00);
    acc(1, 4'ha, 8'h01);
    irq(2'b01);
    acc(1, 4'h0, 8'h00);
    irq(2'b00);
    chk({15'h0000, pe}, 16'h0000);
    acc(0, 4'h8, 8'h00);
    acc(1, 4'h0, 8'h01);
    acc(1, 4'ha, 8'h02);
    for (int i = 0; i < 8; i++) begin
      fl(8'h01 << i, 8'h00, 8'h00, {i < 5, 1'b0});
      acc(1, 4'ha, 8'h06);
      irq({i != 5, 1'b0});
      fl(8'h00, 8'h00, 8'h01 << i, 2'b00);
      acc(1, 4'ha, 8'h02);
    end
    wake <= 1'b1;
    for (int k = 0; k < 9 && ev_irq !== 1'b1; k++) @(posedge clk_sys);
    wake <= 1'b0;
    irq(2'b10);
    acc(0, 4'h8, 8'h20);
    acc(1, 4'h8, 8'h00);
    irq(2'b00);
    ph(8'h00, 8'h04, 4'h0, 8'h09, 16'h0004, 16'h0004);
    ph(8'h80, 8'h04, 4'h3, 8'h09, 16'h0008, 16'h0004);
    ph(8'hc0, 8'h01, 4'h3, 8'h09, 16'h0010, 16'h0009);
    ph(8'h31, 8'h00, 4'h1, 8'h09, 16'h0100, 16'h0100);
    // slow slave outlasts a short rise allowance: high count pauses until the line is seen high
    ph(8'h00, 8'h04, 4'h8, 8'h02, 16'h0004, 16'h000d);
    conclude;
  end
endmodule : i2c_irq_scl_top_bench
`default_nettype wire
